// >>> ussc_host.sv
// Host-side model that pulses bus events into the block
`timescale 1ns/1ps
`default_nettype none
module ussc_host (
   input  wire logic              i_core_clk,
   output var ussc_pkg::ussc_bus_ev_t o_ev
);
   import ussc_pkg::*;
   initial o_ev = '0;
   // One event for one cycle, launched off the falling edge
   task automatic send(input int k);
      @(negedge i_core_clk);
      o_ev = ussc_bus_ev_t'(5'h01 << k);
      @(negedge i_core_clk);
      o_ev = '0;
   endtask : send
endmodule : ussc_host
`default_nettype wire

// >>> ussc_pkg.sv
// Package of constants and types for the USB suspend state control block
// How it works
// [R1] Bus suspend signalling puts device into Suspend
// [R2] Suspend drives sleep_flag_pos high, sleep_flag_neg low
// [R3] Indicators stay asserted after reset until configured
// [R4] Resume, bus reset or device reset exit Suspend
// [R5] Leaving Suspend drives pos low, neg high
// [R6] Indicators undriven while device reset is active
// [R7] Reset pin open-drain; external 15 us low resets
// [R8] Bus-power sense high means connection present
// [R9] Modem lines active low; four in, two out
// [R10] Transmit data driven out, receive data sampled
// [R11] Function controller carries data and serial commands
// [R12] Sense and reset inputs synchronised before use
package ussc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 250;
   localparam int unsigned RST_LOW_MIN_US = 15;
   localparam int unsigned RST_LOW_CYC    = RST_LOW_MIN_US * CLK_MHZ;
   localparam int unsigned RST_CNT_W      = 12;
   localparam logic [RST_CNT_W-1:0] RST_CNT_RST = 12'h000;

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      USSC_ST_UNCONF  = 3'b001,
      USSC_ST_ACTIVE  = 3'b010,
      USSC_ST_SUSPEND = 3'b100
   } ussc_state_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic suspend_det;
      logic resume_det;
      logic resume_gen;
      logic bus_reset;
      logic configured;
   } ussc_bus_ev_t;

   typedef struct packed {
      logic cts_n;
      logic dsr_n;
      logic dcd_n;
      logic ri_n;
   } ussc_modem_in_t;

   typedef struct packed {
      logic rts_n;
      logic dtr_n;
   } ussc_modem_out_t;

endpackage : ussc_pkg

// >>> ussc_sva.sv
// Checker for suspend flags, reset pin and pin pass-through
`timescale 1ns/1ps
`default_nettype none
module ussc_sva (
   input wire logic                      i_core_clk,
   input wire logic                      i_resetn,
   input wire ussc_pkg::ussc_bus_ev_t    i_bus_ev,
   input wire logic                      i_vbus_sense,
   input wire logic                      i_rst_pin,
   input wire logic                      i_rxd,
   input wire ussc_pkg::ussc_modem_in_t  i_modem_n,
   input wire logic                      i_tx_bit,
   input wire ussc_pkg::ussc_modem_out_t i_modem_req_n,
   input wire logic                      o_sleep_flag_pos,
   input wire logic                      o_sleep_flag_pos_oe_n,
   input wire logic                      o_sleep_flag_neg,
   input wire logic                      o_sleep_flag_neg_oe_n,
   input wire logic                      o_rst_pin_out,
   input wire logic                      o_rst_pin_oe_n,
   input wire logic                      o_sys_reset,
   input wire logic                      o_vbus_present,
   input wire logic                      o_suspended,
   input wire logic                      o_txd,
   input wire logic                      o_rx_bit,
   input wire ussc_pkg::ussc_modem_in_t  o_modem_n,
   input wire ussc_pkg::ussc_modem_out_t o_modem_out_n
);
   import ussc_pkg::*;
   logic [11:0] low_q;
   // Raw low run of the pin; saturates so a stuck pin cannot wrap
   always_ff @(posedge i_core_clk) begin
      if (i_rst_pin) low_q <= 12'h000;
      else if (low_q != 12'hFFF) low_q <= low_q + 12'h001;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   chk_susp_entry: assert property (!o_sleep_flag_pos && !o_sys_reset
      && !o_sleep_flag_pos_oe_n && i_bus_ev.suspend_det |=>
      o_sleep_flag_pos && !o_sleep_flag_neg ##1 o_suspended)
      else $error("suspend entry wrong");
   chk_resume_exit: assert property (o_suspended && o_sleep_flag_pos
      && !o_sleep_flag_pos_oe_n && !o_sys_reset && (i_bus_ev.resume_det
      || i_bus_ev.resume_gen || i_bus_ev.bus_reset) |=>
      !o_sleep_flag_pos && o_sleep_flag_neg) else $error("no exit");
   chk_flag_pair: assert property (!o_sleep_flag_pos_oe_n |->
      o_sleep_flag_neg_oe_n == o_sleep_flag_pos_oe_n
      && o_sleep_flag_pos != o_sleep_flag_neg) else $error("flag pair");
   chk_reset_float: assert property (o_sys_reset && $past(o_sys_reset)
      |-> o_sleep_flag_pos_oe_n && o_sleep_flag_neg_oe_n)
      else $error("flags driven in reset");
   chk_unconf_hold: assert property ($fell(o_sys_reset) |-> ##1
      (o_sleep_flag_pos && !o_sleep_flag_neg && !o_sleep_flag_pos_oe_n))
      else $error("flags not asserted after reset");
   chk_rst_count: assert property ($rose(o_sys_reset) |->
      low_q >= RST_LOW_CYC) else $error("reset on short pulse");
   chk_rst_drive: assert property (o_sys_reset && $past(o_sys_reset)
      |-> !o_rst_pin_oe_n && !o_rst_pin_out) else $error("pin not pulled");
   chk_vbus_seen: assert property (i_vbus_sense [*5] |->
      o_vbus_present) else $error("bus power missed");
   chk_serial_out: assert property (!o_sys_reset &&
      !$past(o_sys_reset, 3) |-> o_txd == $past(i_tx_bit)
      && o_modem_out_n == $past(i_modem_req_n)) else $error("serial out");
   chk_serial_in: assert property (!o_sys_reset &&
      !$past(o_sys_reset, 3) |-> o_rx_bit == $past(i_rxd, 3)
      && o_modem_n == $past(i_modem_n, 3)) else $error("serial in");
   cover property (o_suspended);
   cover property ($rose(o_sys_reset));
   cover property (o_sleep_flag_neg && !o_sleep_flag_neg_oe_n);
endmodule : ussc_sva
bind ussc_top ussc_sva ussc_sva_inst (.*);
`default_nettype wire

// >>> ussc_top.sv
// Suspend and resume state control with pin-level serial and reset handling
`timescale 1ns/1ps
`default_nettype none
module ussc_top (
   input  wire logic                      i_core_clk,
   input  wire logic                      i_resetn,
   input  wire ussc_pkg::ussc_bus_ev_t    i_bus_ev,
   input  wire logic                      i_vbus_sense,
   input  wire logic                      i_rst_pin,
   input  wire logic                      i_rxd,
   input  wire ussc_pkg::ussc_modem_in_t  i_modem_n,
   input  wire logic                      i_tx_bit,
   input  wire ussc_pkg::ussc_modem_out_t i_modem_req_n,
   output logic                           o_sleep_flag_pos,
   output logic                           o_sleep_flag_pos_oe_n,
   output logic                           o_sleep_flag_neg,
   output logic                           o_sleep_flag_neg_oe_n,
   output logic                           o_rst_pin_out,
   output logic                           o_rst_pin_oe_n,
   output logic                           o_sys_reset,
   output logic                           o_vbus_present,
   output logic                           o_suspended,
   output logic                           o_txd,
   output logic                           o_rx_bit,
   output ussc_pkg::ussc_modem_in_t       o_modem_n,
   output ussc_pkg::ussc_modem_out_t      o_modem_out_n
);
   import ussc_pkg::*;

   // ----------------------------------------------------------------
   // Synchronisers for pins
   // ----------------------------------------------------------------
   logic [1:0]     vbus_s_q;
   logic [1:0]     rstp_s_q;
   logic [1:0]     rxd_s_q;
   ussc_modem_in_t mdm_s1_q;
   ussc_modem_in_t mdm_s2_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         vbus_s_q <= 2'h0;
         rstp_s_q <= 2'h3;
         rxd_s_q  <= 2'h3;
         mdm_s1_q <= 4'hF;
         mdm_s2_q <= 4'hF;
      end else begin
         vbus_s_q <= {vbus_s_q[0], i_vbus_sense};   // [R12]
         rstp_s_q <= {rstp_s_q[0], i_rst_pin};      // [R12]
         rxd_s_q  <= {rxd_s_q[0], i_rxd};
         mdm_s1_q <= i_modem_n;
         mdm_s2_q <= mdm_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // External reset detection
   // ----------------------------------------------------------------
   // A low pulse must last the full minimum before reset is taken,
   // so short glitches on the open-drain line are ignored.
   logic [RST_CNT_W-1:0] rst_cnt_q;
   logic                 sys_rst_q;
   logic                 ext_rst_hit;

   assign ext_rst_hit = (rst_cnt_q == RST_CNT_W'(RST_LOW_CYC - 1))
                        && !rstp_s_q[1];

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         rst_cnt_q <= RST_CNT_RST;
      end else if (rstp_s_q[1]) begin
         rst_cnt_q <= RST_CNT_RST;
      end else if (!ext_rst_hit) begin
         rst_cnt_q <= rst_cnt_q + 12'h001;          // [R7]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         sys_rst_q <= 1'b1;
      end else begin
         sys_rst_q <= ext_rst_hit;                  // [R7]
      end
   end

   // Device reset: internal reset or a long external low pulse
   logic dev_rst;
   assign dev_rst = sys_rst_q;

   // ----------------------------------------------------------------
   // Suspend state machine
   // ----------------------------------------------------------------
   ussc_state_t state_q;
   ussc_state_t state_d;

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         USSC_ST_UNCONF: begin
            if (i_bus_ev.configured) begin
               state_d = USSC_ST_ACTIVE;            // [R3]
            end
         end
         USSC_ST_ACTIVE: begin
            if (i_bus_ev.suspend_det) begin
               state_d = USSC_ST_SUSPEND;           // [R1]
            end
         end
         USSC_ST_SUSPEND: begin
            if (i_bus_ev.resume_det || i_bus_ev.resume_gen
                || i_bus_ev.bus_reset) begin
               state_d = USSC_ST_ACTIVE;            // [R4]
            end
         end
         default: state_d = USSC_ST_UNCONF;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || dev_rst) begin
         state_q <= USSC_ST_UNCONF;                 // [R4]
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // Sleep indicators
   // ----------------------------------------------------------------
   // During reset both pins are released; the board pull-ups lift them.
   logic asleep;
   assign asleep = (state_d != USSC_ST_ACTIVE);

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn || dev_rst) begin
         o_sleep_flag_pos      <= 1'b1;
         o_sleep_flag_neg      <= 1'b1;
         o_sleep_flag_pos_oe_n <= 1'b1;             // [R6]
         o_sleep_flag_neg_oe_n <= 1'b1;             // [R6]
      end else begin
         o_sleep_flag_pos      <= asleep;           // [R2] [R5]
         o_sleep_flag_neg      <= !asleep;          // [R2] [R5]
         o_sleep_flag_pos_oe_n <= 1'b0;
         o_sleep_flag_neg_oe_n <= 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_suspended <= 1'b0;
      end else begin
         o_suspended <= (state_q == USSC_ST_SUSPEND);
      end
   end

   // ----------------------------------------------------------------
   // Reset pin drive and status
   // ----------------------------------------------------------------
   // Open drain: the data bit stays low and only the enable moves.
   // Limitation: a board that feeds our own pull back in holds reset.
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_rst_pin_out  <= 1'b0;
         o_rst_pin_oe_n <= 1'b0;                    // [R7]
      end else begin
         o_rst_pin_out  <= 1'b0;
         o_rst_pin_oe_n <= !dev_rst;                // [R7]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_sys_reset <= 1'b1;
      end else begin
         o_sys_reset <= dev_rst;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_vbus_present <= 1'b0;
      end else begin
         o_vbus_present <= vbus_s_q[1];             // [R8]
      end
   end

   // ----------------------------------------------------------------
   // Serial and modem pins
   // ----------------------------------------------------------------
   // Lines idle high (mark, and modem lines inactive) after reset.
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_txd <= 1'b1;
      end else begin
         o_txd <= i_tx_bit;                         // [R10] [R11]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_rx_bit <= 1'b1;
      end else begin
         o_rx_bit <= rxd_s_q[1];                    // [R10] [R11]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_modem_n <= 4'hF;
      end else begin
         o_modem_n <= mdm_s2_q;                     // [R9]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_modem_out_n <= 2'h3;
      end else begin
         o_modem_out_n <= i_modem_req_n;            // [R9]
      end
   end

endmodule : ussc_top
`default_nettype wire

// >>> ussc_top_tb.sv
// Self-checking bench for the suspend state control block
`timescale 1ns/1ps
`default_nettype none
module ussc_top_tb;
   import ussc_pkg::*;
   logic            clk = 1'b0, rstn = 1'b0, vbus = 1'b0, rpin = 1'b1;
   logic            tx = 1'b1, rxd = 1'b1;
   logic            rpo, vbp, txd, rxb;
   ussc_modem_in_t  mdm = 4'hF;
   ussc_modem_in_t  mdm_o;
   ussc_modem_out_t mreq_o;
   ussc_modem_out_t mreq = 2'h3;
   ussc_bus_ev_t    ev;
   logic            pos, pos_oe_n, neg, neg_oe_n, rst_oe_n, sys_rst, susp;
   int              error_cnt = 0, num_checks = 0;
   wire logic [3:0] fl = {pos, pos_oe_n, neg, neg_oe_n};
   always #2 clk = ~clk;
   ussc_host ussc_host_inst (.i_core_clk(clk), .o_ev(ev));
   ussc_top ussc_top_inst (.i_core_clk(clk), .i_resetn(rstn),
      .i_bus_ev(ev), .i_vbus_sense(vbus), .i_rst_pin(rpin), .i_rxd(rxd),
      .i_modem_n(mdm), .i_tx_bit(tx), .i_modem_req_n(mreq),
      .o_sleep_flag_pos(pos), .o_sleep_flag_pos_oe_n(pos_oe_n),
      .o_sleep_flag_neg(neg), .o_sleep_flag_neg_oe_n(neg_oe_n),
      .o_rst_pin_out(rpo), .o_rst_pin_oe_n(rst_oe_n), .o_sys_reset(sys_rst),
      .o_vbus_present(vbp), .o_suspended(susp), .o_txd(txd), .o_rx_bit(rxb),
      .o_modem_n(mdm_o), .o_modem_out_n(mreq_o));
   task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc
   task automatic t_reset;
      rstn = 1'b0;
      cyc(5);
      cmp(fl, 4'hF);
      rstn = 1'b1;
      cyc(4);
      cmp(fl, 4'h8);
      cmp({3'h0, susp}, 4'h0);
      ussc_host_inst.send(4);
      cmp(fl, 4'h8);
      $display("test reset done");
   endtask : t_reset
   task automatic t_cfg;
      ussc_host_inst.send(0);
      cmp(fl, 4'h2);
      ussc_host_inst.send(3);
      cmp(fl, 4'h2);
      vbus = 1'b1;
      tx = 1'b0;
      rxd = 1'b0;
      mdm = 4'h5;
      mreq = 2'h1; // Active-low requests pass through
      cyc(6);
      cmp({vbp, txd, rxb, rpo}, 4'h8);
      cmp(mdm_o, 4'h5);
      cmp({2'h0, mreq_o}, 4'h1);
      tx = 1'b1;
      rxd = 1'b1;
      mdm = 4'hA;
      mreq = 2'h2;
      cyc(4);
      cmp({vbp, txd, rxb, rpo}, 4'hE);
      cmp(mdm_o, 4'hA);
      cmp({2'h0, mreq_o}, 4'h2);
      mdm = 4'hF;
      mreq = 2'h3;
      $display("test configure done");
   endtask : t_cfg
   task automatic t_susp(input int k);
      ussc_host_inst.send(4);
      cmp(fl, 4'h8);
      cyc(1);
      cmp({3'h0, susp}, 4'h1);
      ussc_host_inst.send(k);
      cmp(fl, 4'h2);
      $display("test suspend exit done");
   endtask : t_susp
   task automatic t_pin;
      rpin = 1'b0; // Outside party pulls the reset pin
      cyc(3000);
      rpin = 1'b1;
      cyc(4);
      cmp(fl, 4'h2);
      rpin = 1'b0;
      cyc(3760);
      cmp(fl, 4'hF);
      cmp({2'h0, sys_rst, rst_oe_n}, 4'h2);
      rpin = 1'b1;
      for (int i = 0; i < 20 && sys_rst !== 1'b0; i++) cyc(1);
      cmp({3'h0, sys_rst}, 4'h0);
      cyc(2);
      cmp(fl, 4'h8);
      $display("test reset pin done");
   endtask : t_pin
   task automatic results;
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   initial begin
      #60000;
      error_cnt++;
      results;
   end
   initial begin
      t_reset;
      t_cfg;
      for (int k = 3; k > 0; k--) t_susp(k);
      t_pin;
      ussc_host_inst.send(0);
      ussc_host_inst.send(4); // Device reset must also end suspend
      t_reset;
      results;
   end
endmodule : ussc_top_tb
`default_nettype wire
